// *** design/hic_ctx_seq.sv ***
`timescale 1ns/1ns
module hic_ctx_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic switch_req,
  input wire logic dma_outstanding,
  input wire logic engine_busy,
  input wire logic save_done,
  input wire logic final_op,
  output logic save_req,
  output logic block_new_dma,
  output logic saved_set,
  output logic final_set
);
  hic_pkg::hic_seq_t state_reg;
  hic_pkg::hic_seq_t state_next;

  // Drain, save, then wait for software to drop the request
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      hic_pkg::HIC_IDLE: begin
        if (switch_req) begin
          state_next = hic_pkg::HIC_DRAIN;
        end
      end
      hic_pkg::HIC_DRAIN: begin
        if (!dma_outstanding && !engine_busy) begin
          state_next = hic_pkg::HIC_SAVE;
        end
      end
      hic_pkg::HIC_SAVE: begin
        if (save_done) begin
          state_next = hic_pkg::HIC_HOLD;
        end
      end
      hic_pkg::HIC_HOLD: begin
        if (!switch_req) begin
          state_next = hic_pkg::HIC_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= hic_pkg::HIC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Engine handshake and flag events
  assign save_req = (state_reg == hic_pkg::HIC_SAVE);
  assign block_new_dma = (state_reg != hic_pkg::HIC_IDLE);
  assign saved_set = save_req && save_done && !final_op;
  assign final_set = save_req && save_done && final_op;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_drained;
    state_reg == hic_pkg::HIC_DRAIN && !dma_outstanding && !engine_busy;
  endsequence

  sequence s_saved;
    save_req && save_done;
  endsequence

  a_drain_then_save: assert property (s_drained |=> save_req)
    else $error("save not requested after drain");
  a_no_save_while_busy: assert property ($rose(save_req) |-> $past(!engine_busy && !dma_outstanding))
    else $error("save started before drain finished");
  a_final_not_saved: assert property (s_saved ##0 final_op |-> final_set && !saved_set)
    else $error("final hash raised saved state");
  a_saved_on_partial: assert property (s_saved ##0 !final_op |-> saved_set ##1 !save_req)
    else $error("partial save did not raise saved state");
endmodule

// *** design/hic_engine_ctrl.sv ***
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - A context switch request drains outstanding DMA input requests, blocks new ones, waits for the engine to idle, then saves the context.
// - DMA requests leave the block only while the DMA gate bit 3 of the setup register is 1, which resets to 0.
// - The general interrupt output rises for a flag only when the global gate bit 2 and that flag's mask bit are both 1.
// - The partial interrupt output follows the saved state flag gated only by the global gate, not the masks.
// - Flag bit 3 shows that the context input registers can take a new context, and reads 1 out of reset.
// - Flag bit 2 shows that a saved context can be fetched after a switch request, and reads 0 out of reset.
// - A switch that lands on a final or outer hash leaves the saved flag low and raises a final result instead.
// - Flag bit 1 shows that the data FIFO can take the next 64-byte block, and reads 0 out of reset.
// - Flag bit 0 shows that a partial or final result or a saved context can be read.
// - Each flag has a read-write mask bit in the same position, each resetting to 0.
// - The flags are read-only and software writes leave them unchanged.
module hic_engine_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [hic_pkg::HIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [hic_pkg::HIC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hic_pkg::HIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [hic_pkg::HIC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_data_want,
  input wire logic dma_ctx_want,
  output logic dma_data_req,
  output logic dma_ctx_req,
  input wire logic engine_busy,
  input wire logic ctx_in_free,
  input wire logic fifo_ready,
  input wire logic result_ready,
  input wire logic final_op,
  input wire logic save_done,
  input wire logic ctx_out_read,
  output logic save_req,
  output logic result_is_final,
  output logic general_irq_out,
  output logic partial_irq_out
);
  // Decode a byte address into a register select
  function automatic logic [1:0] hic_sel(input logic [hic_pkg::HIC_ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = hic_pkg::HIC_SEL_NONE;
    if (addr == hic_pkg::HIC_SETUP_OFF) begin
      sel = hic_pkg::HIC_SEL_SETUP;
    end else if (addr == hic_pkg::HIC_FLAGS_OFF) begin
      sel = hic_pkg::HIC_SEL_FLAGS;
    end else if (addr == hic_pkg::HIC_MASKS_OFF) begin
      sel = hic_pkg::HIC_SEL_MASKS;
    end
    return sel;
  endfunction

  logic context_switch_request;
  logic dma_request_gate;
  logic global_irq_gate;
  logic [3:0] mask_reg;
  logic [3:0] flags_reg;
  logic saved_state_avail_flag;
  logic final_reg;
  logic data_held_reg;
  logic ctx_held_reg;
  logic block_new_dma;
  logic saved_set;
  logic final_set;
  logic aw_got_reg;
  logic w_got_reg;
  logic [hic_pkg::HIC_ADDR_W-1:0] awaddr_reg;
  logic [hic_pkg::HIC_DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [hic_pkg::HIC_DATA_W-1:0] rdata_reg;
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic [hic_pkg::HIC_ADDR_W-1:0] wr_addr;
  logic [hic_pkg::HIC_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [1:0] wr_sel;
  logic [hic_pkg::HIC_DATA_W-1:0] rd_word;

  // Context save sequencer
  hic_ctx_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .switch_req(context_switch_request),
    .dma_outstanding(dma_data_req || dma_ctx_req),
    .engine_busy(engine_busy),
    .save_done(save_done),
    .final_op(final_op),
    .save_req(save_req),
    .block_new_dma(block_new_dma),
    .saved_set(saved_set),
    .final_set(final_set)
  );

  // DMA requests: a request already raised may finish during a drain, a new one may not
  assign dma_data_req = dma_request_gate && dma_data_want && (!block_new_dma || data_held_reg);
  assign dma_ctx_req = dma_request_gate && dma_ctx_want && (!block_new_dma || ctx_held_reg);

  // Remember which requests are under way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_held_reg <= 1'b0;
      ctx_held_reg <= 1'b0;
    end else begin
      data_held_reg <= dma_data_req;
      ctx_held_reg <= dma_ctx_req;
    end
  end

  // Saved state and final result levels, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_state_avail_flag <= 1'b0;
      final_reg <= 1'b0;
    end else begin
      saved_state_avail_flag <= saved_set || (saved_state_avail_flag && !ctx_out_read);
      final_reg <= final_set || (final_reg && !ctx_out_read);
    end
  end

  // Flag levels follow the engine, no bus path writes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= hic_pkg::HIC_FLAGS_RST;
    end else begin
      flags_reg[hic_pkg::HIC_CTX_FREE_BIT] <= ctx_in_free;
      flags_reg[hic_pkg::HIC_SAVED_BIT] <= saved_state_avail_flag;
      flags_reg[hic_pkg::HIC_INPUT_BIT] <= fifo_ready;
      flags_reg[hic_pkg::HIC_OUTPUT_BIT] <= result_ready || saved_state_avail_flag || final_reg;
    end
  end

  assign result_is_final = final_reg;

  // Interrupt outputs
  assign general_irq_out = global_irq_gate && ((flags_reg & mask_reg) != 4'h0);
  assign partial_irq_out = global_irq_gate && flags_reg[hic_pkg::HIC_SAVED_BIT];

  // Write channel acceptance, address and data in either order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign do_write = (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
  assign wr_addr = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_got_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_sel = hic_sel(wr_addr);

  // Hold whichever half of a write arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_got_reg <= !do_write && (aw_got_reg || aw_fire);
      w_got_reg <= !do_write && (w_got_reg || w_fire);
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= hic_pkg::HIC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == hic_pkg::HIC_SEL_NONE) ? hic_pkg::HIC_RESP_SLVERR : hic_pkg::HIC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Setup register, all fields in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      context_switch_request <= hic_pkg::HIC_CTX_SWITCH_RST;
      dma_request_gate <= hic_pkg::HIC_DMA_GATE_RST;
      global_irq_gate <= hic_pkg::HIC_IRQ_GATE_RST;
    end else if (do_write && wr_sel == hic_pkg::HIC_SEL_SETUP && wr_strb[0]) begin
      context_switch_request <= wr_data[hic_pkg::HIC_CTX_SWITCH_BIT];
      dma_request_gate <= wr_data[hic_pkg::HIC_DMA_GATE_BIT];
      global_irq_gate <= wr_data[hic_pkg::HIC_IRQ_GATE_BIT];
    end
  end

  // Mask register; writes to the flags address land nowhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= hic_pkg::HIC_MASKS_RST;
    end else if (do_write && wr_sel == hic_pkg::HIC_SEL_MASKS && wr_strb[0]) begin
      mask_reg <= wr_data[3:0];
    end
  end

  // Read data mux, reserved bits read zero
  always_comb begin
    rd_word = '0;
    unique case (hic_sel(s_axi_araddr))
      hic_pkg::HIC_SEL_SETUP: begin
        rd_word[hic_pkg::HIC_CTX_SWITCH_BIT] = context_switch_request;
        rd_word[hic_pkg::HIC_DMA_GATE_BIT] = dma_request_gate;
        rd_word[hic_pkg::HIC_IRQ_GATE_BIT] = global_irq_gate;
      end
      hic_pkg::HIC_SEL_FLAGS: rd_word[3:0] = flags_reg;
      hic_pkg::HIC_SEL_MASKS: rd_word[3:0] = mask_reg;
      hic_pkg::HIC_SEL_NONE: rd_word = '0;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= hic_pkg::HIC_RESP_OKAY;
      rdata_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= (hic_sel(s_axi_araddr) == hic_pkg::HIC_SEL_NONE) ? hic_pkg::HIC_RESP_SLVERR
                                                                     : hic_pkg::HIC_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dma_gate_off: assert property (!dma_request_gate |-> !dma_data_req && !dma_ctx_req)
    else $error("DMA request with gate off");
  a_no_new_dma: assert property ($rose(dma_data_req) || $rose(dma_ctx_req) |-> !block_new_dma)
    else $error("new DMA request during context switch");
  a_general_irq: assert property (global_irq_gate && mask_reg[0] && $past(result_ready) |-> general_irq_out)
    else $error("general interrupt missing");
  a_irq_needs_gate: assert property (general_irq_out || partial_irq_out |-> global_irq_gate)
    else $error("interrupt without global gate");
  a_partial_irq: assert property (saved_set ##2 global_irq_gate |-> partial_irq_out)
    else $error("partial interrupt missing");
  a_flags_reset: assert property ($past(!aresetn) |-> flags_reg == 4'h8)
    else $error("flags wrong after reset");
  a_saved_holds: assert property (saved_state_avail_flag && !ctx_out_read |=> saved_state_avail_flag)
    else $error("saved state dropped before read");
  a_final_output: assert property (final_set |=> ##1 flags_reg[0] && !flags_reg[2])
    else $error("final result not shown");
  a_input_follow: assert property (fifo_ready |=> flags_reg[1])
    else $error("input ready not shown");
  a_output_saved: assert property (saved_state_avail_flag |=> flags_reg[0])
    else $error("output ready not shown for saved context");
  a_mask_write: assert property (do_write && wr_sel == hic_pkg::HIC_SEL_MASKS && wr_strb[0]
                                 |=> mask_reg == $past(wr_data[3:0]))
    else $error("mask write lost");
  a_flags_ro: assert property (do_write && wr_sel == hic_pkg::HIC_SEL_FLAGS
                               |=> $stable(mask_reg) && $stable(dma_request_gate)
                               && flags_reg[hic_pkg::HIC_INPUT_BIT] == $past(fifo_ready))
    else $error("flags write changed state");
  a_level_drop: assert property (!fifo_ready ##1 !fifo_ready |=> !flags_reg[1])
    else $error("input ready did not drop");
  a_ctx_free_follow: assert property (ctx_in_free |=> flags_reg[hic_pkg::HIC_CTX_FREE_BIT])
    else $error("context free not shown");
  a_result_follow: assert property (result_ready |=> flags_reg[hic_pkg::HIC_OUTPUT_BIT])
    else $error("output ready not shown for result");
  a_partial_unmasked: assert property (global_irq_gate && flags_reg[hic_pkg::HIC_SAVED_BIT]
                                       |-> partial_irq_out)
    else $error("partial interrupt held back");
  a_setup_dma_bit: assert property (do_write && wr_sel == hic_pkg::HIC_SEL_SETUP && wr_strb[0]
                                    |=> dma_request_gate == $past(wr_data[hic_pkg::HIC_DMA_GATE_BIT]))
    else $error("DMA gate write lost");
  a_saved_clear: assert property (saved_state_avail_flag && ctx_out_read && !saved_set
                                  |=> !saved_state_avail_flag)
    else $error("saved state not cleared by read");
endmodule

// *** design/hic_pkg.sv ***
package hic_pkg;
  // Register bus geometry
  localparam int HIC_ADDR_W = 12;
  localparam int HIC_DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] HIC_SETUP_OFF = 12'h110;
  localparam logic [11:0] HIC_FLAGS_OFF = 12'h118;
  localparam logic [11:0] HIC_MASKS_OFF = 12'h11c;

  // Fields of engine_system_setup
  localparam int HIC_CTX_SWITCH_BIT = 6;
  localparam int HIC_DMA_GATE_BIT = 3;
  localparam int HIC_IRQ_GATE_BIT = 2;
  localparam logic HIC_CTX_SWITCH_RST = 1'b0;
  localparam logic HIC_DMA_GATE_RST = 1'b0;
  localparam logic HIC_IRQ_GATE_RST = 1'b0;

  // Fields of engine_irq_flags and engine_irq_masks
  localparam int HIC_CTX_FREE_BIT = 3;
  localparam int HIC_SAVED_BIT = 2;
  localparam int HIC_INPUT_BIT = 1;
  localparam int HIC_OUTPUT_BIT = 0;
  localparam logic [3:0] HIC_FLAGS_RST = 4'h8;
  localparam logic [3:0] HIC_MASKS_RST = 4'h0;

  // AXI response codes
  localparam logic [1:0] HIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] HIC_RESP_SLVERR = 2'h2;

  // Register select codes
  localparam logic [1:0] HIC_SEL_SETUP = 2'h0;
  localparam logic [1:0] HIC_SEL_FLAGS = 2'h1;
  localparam logic [1:0] HIC_SEL_MASKS = 2'h2;
  localparam logic [1:0] HIC_SEL_NONE = 2'h3;

  // Context switch sequencer states
  typedef enum logic [1:0] {HIC_IDLE, HIC_DRAIN, HIC_SAVE, HIC_HOLD} hic_seq_t;
endpackage

// *** testbench/hic_engine_ctrl_test.sv ***
`timescale 1ns/1ns
module hic_engine_ctrl_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic dma_data_want, dma_ctx_want, dma_data_req, dma_ctx_req, engine_busy, save_done, save_req;
  logic result_is_final, general_irq_out, partial_irq_out;
  logic ctx_in_free = 1'b1, fifo_ready = 1'b0, result_ready = 1'b0, final_op = 1'b0, ctx_out_read = 1'b0;
  logic start_work = 1'b0;
  logic [3:0] lat = 4'h2;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [3:0] m, fl;
  logic g;

  always #50 aclk = ~aclk;

  hic_engine_ctrl hic_engine_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dma_data_want, .dma_ctx_want, .dma_data_req, .dma_ctx_req, .engine_busy, .ctx_in_free, .fifo_ready,
    .result_ready, .final_op, .save_done, .ctx_out_read, .save_req, .result_is_final, .general_irq_out,
    .partial_irq_out);
  hic_engine_model hic_engine_model_i (.aclk, .aresetn, .start_work, .lat, .dma_data_req, .dma_ctx_req,
    .save_req, .dma_data_want, .dma_ctx_want, .engine_busy, .save_done);

  // Counts and verdict, then stop
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Write one word: offer address and data together, hold each until taken, then take the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw, w;
    k = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w && s_axi_bvalid) && k < 64) begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // A write that never completes ends the run as a failure
    if (!(aw && w && s_axi_bvalid)) begin
      mismatches++;
      final_report;
    end
    r = s_axi_bresp;
  endtask

  // Read one word, data and response taken at the edge that sees rvalid
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ar;
    k = 0;
    ar = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!(ar && s_axi_rvalid) && k < 64) begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    // A read that never completes ends the run as a failure
    if (!(ar && s_axi_rvalid)) begin
      mismatches++;
      final_report;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  function automatic logic exp_irq(input logic gate, input logic [3:0] mask, input logic [3:0] flags);
    return gate && |(flags & mask);
  endfunction

  // Hang guard
  initial begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    final_report;
  end

  initial begin
    void'($urandom(32'h7bf6));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, then unmapped places
    rd_reg(hic_pkg::HIC_SETUP_OFF, rd, rs);
    chk(rd, 32'h0, "setup reset");
    rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
    chk(rd, 32'h8, "flags reset");
    rd_reg(hic_pkg::HIC_MASKS_OFF, rd, rs);
    chk(rd, 32'h0, "masks reset");
    rd_reg(12'h120, rd, rs);
    chk({30'h0, rs}, {30'h0, hic_pkg::HIC_RESP_SLVERR}, "unmapped read");
    wr(12'h124, 32'hf, rs);
    chk({30'h0, rs}, {30'h0, hic_pkg::HIC_RESP_SLVERR}, "unmapped write");
    // Byte lane 0 off: the mask write must not land
    s_axi_wstrb <= 4'he;
    wr(hic_pkg::HIC_MASKS_OFF, 32'hf, rs);
    s_axi_wstrb <= 4'hf;
    chk({30'h0, rs}, {30'h0, hic_pkg::HIC_RESP_OKAY}, "lane off resp");
    rd_reg(hic_pkg::HIC_MASKS_OFF, rd, rs);
    chk(rd, 32'h0, "masks lane off");
    // Random masks, gate and engine levels, with corners first
    for (int i = 0; i < 24; i++) begin
      m = 4'($urandom);
      g = 1'($urandom);
      fl = 4'($urandom) & 4'hb;
      if (i < 2) fl = 4'hb;
      if (i < 2) m = i == 0 ? 4'hf : 4'h0;
      if (i < 2) g = i == 0 ? 1'b0 : 1'b1;
      ctx_in_free <= fl[3];
      fifo_ready <= fl[1];
      result_ready <= fl[0];
      wr(hic_pkg::HIC_SETUP_OFF, {29'h0, g, 2'h0}, rs);
      wr(hic_pkg::HIC_MASKS_OFF, {28'h0, m}, rs);
      wr(hic_pkg::HIC_FLAGS_OFF, $urandom, rs);
      chk({30'h0, rs}, {30'h0, hic_pkg::HIC_RESP_OKAY}, "flags write resp");
      rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
      chk(rd, {28'h0, fl}, "flags");
      rd_reg(hic_pkg::HIC_MASKS_OFF, rd, rs);
      chk(rd, {28'h0, m}, "masks");
      chk1(general_irq_out, exp_irq(g, m, fl), "general irq");
      chk1(partial_irq_out, 1'b0, "partial irq");
    end
    // Gate off keeps requests down, gate on lets them out
    ctx_in_free <= 1'b1;
    fifo_ready <= 1'b0;
    result_ready <= 1'b0;
    wr(hic_pkg::HIC_MASKS_OFF, 32'h0, rs);
    wr(hic_pkg::HIC_SETUP_OFF, 32'h0, rs);
    start_work <= 1'b1;
    @(posedge aclk);
    start_work <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({30'h0, dma_data_req, dma_ctx_req}, 32'h0, "dma gated");
    wr(hic_pkg::HIC_SETUP_OFF, 32'h8, rs);
    repeat (2) @(posedge aclk);
    chk({30'h0, dma_data_want, dma_ctx_want}, 32'h0, "dma served");
    // Context switch on a busy engine: no new requests, drain, save, saved flag, then read out
    lat <= 4'hf;
    start_work <= 1'b1;
    @(posedge aclk);
    start_work <= 1'b0;
    wr(hic_pkg::HIC_SETUP_OFF, 32'h4c, rs);
    start_work <= 1'b1;
    @(posedge aclk);
    start_work <= 1'b0;
    lat <= 4'h3;
    repeat (2) @(posedge aclk);
    chk({30'h0, dma_data_req, dma_ctx_req}, 32'h0, "no new dma");
    chk1(save_req, 1'b0, "save waits for engine");
    for (n = 0; n < 40 && save_req !== 1'b1; n++) @(posedge aclk);
    chk1(save_req, 1'b1, "save asked");
    repeat (8) @(posedge aclk);
    rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
    chk(rd, 32'hd, "saved flags");
    chk1(partial_irq_out, 1'b1, "partial irq on");
    chk1(general_irq_out, 1'b0, "general masked");
    wr(hic_pkg::HIC_MASKS_OFF, 32'h4, rs);
    chk1(general_irq_out, 1'b1, "general on");
    ctx_out_read <= 1'b1;
    @(posedge aclk);
    ctx_out_read <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
    chk(rd, 32'h8, "saved cleared");
    chk1(partial_irq_out, 1'b0, "partial off");
    wr(hic_pkg::HIC_SETUP_OFF, 32'hc, rs);
    repeat (3) @(posedge aclk);
    chk({30'h0, dma_data_want, dma_ctx_want}, 32'h0, "dma resumed");
    // Switch on a final hash: result flagged final, saved flag stays low
    final_op <= 1'b1;
    wr(hic_pkg::HIC_SETUP_OFF, 32'h4c, rs);
    for (n = 0; n < 40 && save_req !== 1'b1; n++) @(posedge aclk);
    repeat (8) @(posedge aclk);
    rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
    chk(rd, 32'h9, "final flags");
    chk1(result_is_final, 1'b1, "final result");
    chk1(partial_irq_out, 1'b0, "no partial irq");
    // Reset in mid-run brings every register back
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(hic_pkg::HIC_SETUP_OFF, rd, rs);
    chk(rd, 32'h0, "setup after reset");
    rd_reg(hic_pkg::HIC_FLAGS_OFF, rd, rs);
    chk(rd, 32'h8, "flags after reset");
    rd_reg(hic_pkg::HIC_MASKS_OFF, rd, rs);
    chk(rd, 32'h0, "masks after reset");
    chk1(result_is_final, 1'b0, "final after reset");
    final_report;
  end
endmodule

// *** testbench/hic_engine_model.sv ***
`timescale 1ns/1ns
module hic_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start_work,
  input wire logic [3:0] lat,
  input wire logic dma_data_req,
  input wire logic dma_ctx_req,
  input wire logic save_req,
  output logic dma_data_want,
  output logic dma_ctx_want,
  output logic engine_busy,
  output logic save_done
);
  logic [3:0] busy_cnt_reg;
  logic [3:0] save_cnt_reg;
  // Wants stay up until the block raises the matching request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_data_want <= 1'b0;
      dma_ctx_want <= 1'b0;
    end else begin
      dma_data_want <= start_work || (dma_data_want && !dma_data_req);
      dma_ctx_want <= start_work || (dma_ctx_want && !dma_ctx_req);
    end
  end
  // Buffered work keeps the engine busy for lat cycles after each start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_reg <= 4'h0;
    end else begin
      busy_cnt_reg <= start_work ? lat : busy_cnt_reg - {3'h0, busy_cnt_reg != 4'h0};
    end
  end
  assign engine_busy = busy_cnt_reg != 4'h0;
  // Saving takes lat+1 cycles, then one done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      save_cnt_reg <= 4'h0;
      save_done <= 1'b0;
    end else begin
      save_done <= save_req && !save_done && save_cnt_reg == lat;
      save_cnt_reg <= (save_req && !save_done) ? save_cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule
